// ==== ddrs_beat_cap.sv ====
// One write beat capture cell, clocked by one leg of a write data clock
// Assumes the clock leg is free running; the late cell also copies the
// beat held by the early cell, which changes only half a period away
`timescale 1ns/1ns
`include "ddrs_defs.svh"

module ddrs_beat_cap
    import ddrs_pkg::*;
#(
    parameter bit LATE = 1'b0
) (
    input wire logic capClk,
    input wire logic nrst,
    input wire logic [`DDRS_PAIR_W-1:0] laneData,
    input wire logic maskIn,
    input wire logic [`DDRS_PAIR_W-1:0] earlyBeat,
    input wire logic earlyMask,
    output logic [`DDRS_PAIR_W-1:0] beat,
    output logic mask,
    output logic [`DDRS_PAIR_W-1:0] heldEarly,
    output logic heldEarlyMask,
    output logic tog
);

    ddrs_cap_s s_q;
    ddrs_cap_s s_d;

    // ==========================================================
    // Capture data and mask on every rising edge of this leg
    always_comb begin
        s_d = s_q;
        s_d.beat = laneData;
        s_d.mask = maskIn;
        if (LATE) begin
            // Pair the early beat with this one and announce the pair
            s_d.early = earlyBeat;
            s_d.earlyMask = earlyMask;
            s_d.tog = ~s_q.tog;
        end
    end

    // State register
    always_ff @(posedge capClk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign beat = s_q.beat;
    assign mask = s_q.mask;
    assign heldEarly = s_q.early;
    assign heldEarlyMask = s_q.earlyMask;
    assign tog = s_q.tog;

endmodule : ddrs_beat_cap

// ==== ddrs_ctrl_model.sv ====
// Memory controller model: command pins, link and write clocks, write data
// Assumes the bench resolves the data wires between it and the device
`timescale 1ns/1ns

module ddrs_ctrl_model
    import ddrs_pkg::*;
(
    output logic commandClock,
    output logic cmdSelN,
    output logic cmdWriteN,
    output logic cmdRefreshN,
    output logic [19:0] addrIn,
    output logic [3:0] bankIn,
    output logic spareSelectBall,
    output logic [1:0] writeDataClock,
    output logic [1:0] writeDataClockN,
    output logic [1:0] writeByteMask,
    output logic [35:0] dqIn
);
    logic dk;

    // ====
    // Free running clocks, 30 ns, phases unrelated to the core clock
    assign writeDataClock = {2{dk}};
    assign writeDataClockN = {2{~dk}};
    initial begin
        {commandClock, dk, spareSelectBall} = 3'h0;
        {cmdSelN, cmdRefreshN, cmdWriteN} = 3'h7;
        {addrIn, bankIn, writeByteMask} = 26'h0000000;
        dqIn = 36'h000000000;
        fork
            #7 forever #15 commandClock = ~commandClock;
            #4 forever #15 dk = ~dk;
        join
    end

    // One command at the next link rise
    task automatic drive_cmd(input logic sel, input logic [1:0] code,
        input logic [19:0] a, input logic [3:0] b);
        @(posedge commandClock);
        #2;
        cmdSelN = sel;
        {cmdRefreshN, cmdWriteN} = code;
        addrIn = a;
        bankIn = b;
        spareSelectBall = ~a[5];
    endtask : drive_cmd

    // Deselect; released pins other than spareSelectBall flip so no stale value lingers on them
    task automatic idle_cmd();
        @(posedge commandClock);
        #2;
        cmdSelN = 1'b1;
        {cmdRefreshN, cmdWriteN, addrIn, bankIn} =
            ~{cmdRefreshN, cmdWriteN, addrIn, bankIn};
    endtask : idle_cmd

    // Rising beat first, falling beat second, then junk
    task automatic write_pair(input logic [35:0] a, input logic [35:0] b,
        input logic [1:0] ma, input logic [1:0] mb);
        @(negedge dk);
        #2;
        {dqIn, writeByteMask} = {a, ma};
        @(posedge dk);
        #2;
        {dqIn, writeByteMask} = {b, mb};
        @(negedge dk);
        #2;
        {dqIn, writeByteMask} = ~{b, mb};
    endtask : write_pair
endmodule : ddrs_ctrl_model

// ==== ddrs_defs.svh ====
// Constants of the DRAM pin interface: widths, lane layout, reset values
// Assumes inclusion by bare name from the package and the design modules
`ifndef DDRS_DEFS_SVH
`define DDRS_DEFS_SVH

// ==========================================================
// Pin widths
`define DDRS_ADDR_W 20
`define DDRS_BANK_W 4
`define DDRS_DQ_W 36
`define DDRS_LANE_W 9
`define DDRS_LANES 4
`define DDRS_PAIRS 2
`define DDRS_PAIR_W 18

// ==========================================================
// Field positions
`define DDRS_MIRROR_BIT 5
`define DDRS_UPPER_LANE_OFS 18

// ==========================================================
// Build and reset values
`define DDRS_BUILD36 1'b1
`define DDRS_RST_ECHO 1'b0
`define DDRS_RST_ADDR 20'h00000
`define DDRS_RST_BANK 4'h0
`define DDRS_RST_DQ 36'h000000000
`define DDRS_RST_PAIR 18'h00000

// ==========================================================
// Timing: core clock period, shortest link clock period, core cycles per link cycle
`define DDRS_CLK_NS 10
`define DDRS_LINK_MIN_NS 30
`define DDRS_LINK_CYC ((`DDRS_LINK_MIN_NS) / (`DDRS_CLK_NS))

`endif

// ==== ddrs_pin_if.sv ====
// Pin-level command, address and data interface of a 16-bank DRAM
// Assumes the core logic runs on clk, the controller launches commands on
// commandClock and write data on free-running writeDataClock pairs, and
// the testbench resolves the data wires from dqOut and dqOe
`timescale 1ns/1ns
`include "ddrs_defs.svh"

module ddrs_pin_if
    import ddrs_pkg::*;
#(
    parameter bit WIDE_BUILD = `DDRS_BUILD36
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic commandClock,
    input wire logic cmdSelN,
    input wire logic cmdWriteN,
    input wire logic cmdRefreshN,
    input wire logic [`DDRS_ADDR_W-1:0] addrIn,
    input wire logic [`DDRS_BANK_W-1:0] bankIn,
    input wire logic mirrorSelect,
    input wire logic spareSelectBall,
    input wire logic [`DDRS_PAIRS-1:0] writeDataClock,
    input wire logic [`DDRS_PAIRS-1:0] writeDataClockN,
    input wire logic [`DDRS_PAIRS-1:0] writeByteMask,
    input wire logic [`DDRS_DQ_W-1:0] dqIn,
    output logic [`DDRS_DQ_W-1:0] dqOut,
    output logic dqOe,
    output logic [`DDRS_LANES-1:0] readEchoClock,
    output logic [`DDRS_LANES-1:0] readEchoClockN,
    output logic [1:0] readValidFlag,
    output logic cmdValid,
    output ddrs_cmd_e cmdKind,
    output logic [`DDRS_BANK_W-1:0] cmdBank,
    output logic [`DDRS_ADDR_W-1:0] cmdAddr,
    output logic [`DDRS_PAIRS-1:0] wrValid,
    output logic [`DDRS_DQ_W-1:0] wrRiseData,
    output logic [`DDRS_DQ_W-1:0] wrFallData,
    output logic [`DDRS_LANES-1:0] wrRiseLaneEn,
    output logic [`DDRS_LANES-1:0] wrFallLaneEn,
    input wire logic rdBeatValid,
    input wire logic [`DDRS_DQ_W-1:0] rdBeatData
);

    ddrs_link_s l_q;
    ddrs_link_s l_d;
    ddrs_core_s c_q;
    ddrs_core_s c_d;

    // Capture cell inputs and outputs, one entry per write clock pair
    logic [`DDRS_PAIRS-1:0][`DDRS_PAIR_W-1:0] riseBeat;
    logic [`DDRS_PAIRS-1:0] riseMask;
    logic [`DDRS_PAIRS-1:0][`DDRS_PAIR_W-1:0] fallBeat;
    logic [`DDRS_PAIRS-1:0] fallMask;
    logic [`DDRS_PAIRS-1:0][`DDRS_PAIR_W-1:0] pairEarly;
    logic [`DDRS_PAIRS-1:0] pairEarlyMask;
    logic [`DDRS_PAIRS-1:0] pairTog;
    logic [`DDRS_PAIRS-1:0][`DDRS_PAIR_W-1:0] pairLanes;

    // ==========================================================
    // Command clock domain
    // ==========================================================

    // Decode and hold one command per accepted rising edge
    always_comb begin
        logic [`DDRS_ADDR_W-1:0] a;
        ddrs_cmd_e k;
        a = addrIn;
        k = DDRS_NOP;
        // Static layout strap, synchronised before use
        l_d = l_q;
        l_d.mirSync1 = mirrorSelect;
        l_d.mirSync2 = l_q.mirSync1;
        if (l_q.mirSync2) begin
            a[`DDRS_MIRROR_BIT] = spareSelectBall;
        end
        // Write and refresh pins select the operation
        if (!cmdWriteN && !cmdRefreshN) begin
            k = DDRS_CFG;
        end else if (!cmdWriteN) begin
            k = DDRS_WRITE;
        end else if (!cmdRefreshN) begin
            k = DDRS_REFRESH;
        end else begin
            k = DDRS_READ;
        end
        // Decoder enabled only while the device is selected
        if (!cmdSelN) begin
            l_d.addr = a;
            l_d.bank = bankIn;
            l_d.kind = k;
            l_d.tog = ~l_q.tog;
        end
    end

    // Rising edge of the true clock only
    always_ff @(posedge commandClock or negedge nrst) begin
        if (!nrst) begin
            l_q.mirSync1 <= 1'b0;
            l_q.mirSync2 <= 1'b0;
            l_q.addr <= `DDRS_RST_ADDR;
            l_q.bank <= `DDRS_RST_BANK;
            l_q.kind <= DDRS_NOP;
            l_q.tog <= 1'b0;
        end else begin
            l_q <= l_d;
        end
    end

    // ==========================================================
    // Write data clock domains
    // ==========================================================

    // Lane routing: pair p owns lanes p and p+2
    genvar p;
    generate
        for (p = 0; p < `DDRS_PAIRS; p++) begin : gPair
            assign pairLanes[p] = {
                dqIn[p*`DDRS_LANE_W+`DDRS_UPPER_LANE_OFS +: `DDRS_LANE_W],
                dqIn[p*`DDRS_LANE_W +: `DDRS_LANE_W]
            };

            // First beat of each pair on the rising edge
            ddrs_beat_cap #(
                .LATE(1'b0)
            ) uRise (
                .capClk(writeDataClock[p]),
                .nrst(nrst),
                .laneData(pairLanes[p]),
                .maskIn(writeByteMask[p]),
                .earlyBeat(`DDRS_RST_PAIR),
                .earlyMask(1'b0),
                .beat(riseBeat[p]),
                .mask(riseMask[p]),
                .heldEarly(),
                .heldEarlyMask(),
                .tog()
            );

            // Second beat on the complement rising, i.e. true falling
            ddrs_beat_cap #(
                .LATE(1'b1)
            ) uFall (
                .capClk(writeDataClockN[p]),
                .nrst(nrst),
                .laneData(pairLanes[p]),
                .maskIn(writeByteMask[p]),
                .earlyBeat(riseBeat[p]),
                .earlyMask(riseMask[p]),
                .beat(fallBeat[p]),
                .mask(fallMask[p]),
                .heldEarly(pairEarly[p]),
                .heldEarlyMask(pairEarlyMask[p]),
                .tog(pairTog[p])
            );
        end
    endgenerate

    // ==========================================================
    // Core clock domain
    // ==========================================================

    // Toggle crossings, write beat delivery and read launch
    always_comb begin
        logic lanesHi;
        c_d = c_q;
        lanesHi = WIDE_BUILD;

        // Command toggle crossing; stage 0 feeds stage 1 only
        c_d.cmdSync = {c_q.cmdSync[1:0], l_q.tog};
        c_d.cmdValid = c_q.cmdSync[2] ^ c_q.cmdSync[1];
        if (c_q.cmdSync[2] ^ c_q.cmdSync[1]) begin
            c_d.cmdKind = l_q.kind;
            c_d.cmdBank = l_q.bank;
            c_d.cmdAddr = l_q.addr;
        end

        // Write beat pairs, one toggle per write clock period
        for (int i = 0; i < `DDRS_PAIRS; i++) begin
            c_d.wrSync[i] = {c_q.wrSync[i][1:0], pairTog[i]};
            c_d.wrValid[i] = c_q.wrSync[i][2] ^ c_q.wrSync[i][1];
            if (c_q.wrSync[i][2] ^ c_q.wrSync[i][1]) begin
                c_d.wrRise[i*`DDRS_LANE_W +: `DDRS_LANE_W] =
                    pairEarly[i][`DDRS_LANE_W-1:0];
                c_d.wrRise[i*`DDRS_LANE_W+`DDRS_UPPER_LANE_OFS
                    +: `DDRS_LANE_W] =
                    pairEarly[i][`DDRS_PAIR_W-1:`DDRS_LANE_W];
                c_d.wrFall[i*`DDRS_LANE_W +: `DDRS_LANE_W] =
                    fallBeat[i][`DDRS_LANE_W-1:0];
                c_d.wrFall[i*`DDRS_LANE_W+`DDRS_UPPER_LANE_OFS
                    +: `DDRS_LANE_W] =
                    fallBeat[i][`DDRS_PAIR_W-1:`DDRS_LANE_W];
                // Mask high blocks the lanes of this pair
                c_d.wrRiseEn[i] = ~pairEarlyMask[i];
                c_d.wrRiseEn[i+2] = ~pairEarlyMask[i] & lanesHi;
                c_d.wrFallEn[i] = ~fallMask[i];
                c_d.wrFallEn[i+2] = ~fallMask[i] & lanesHi;
            end
        end

        // Read stage: flag one cycle ahead of the beat on the pins
        c_d.rdStageV = rdBeatValid;
        c_d.rdStageD = rdBeatData;
        c_d.rdFlag = rdBeatValid;
        c_d.dqOe = c_q.rdStageV;
        if (c_q.rdStageV) begin
            c_d.dqOut = c_q.rdStageD;
        end
        // Unused upper lanes stay quiet in the narrow build
        if (!lanesHi) begin
            c_d.dqOut[`DDRS_DQ_W-1:`DDRS_PAIR_W] = `DDRS_RST_PAIR;
        end

        // Echo clock changes on every rising core edge, as the data does
        c_d.echo = ~c_q.echo;
    end

    // Core state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            c_q.cmdSync <= 3'h0;
            c_q.wrSync <= '0;
            c_q.cmdValid <= 1'b0;
            c_q.cmdKind <= DDRS_NOP;
            c_q.cmdBank <= `DDRS_RST_BANK;
            c_q.cmdAddr <= `DDRS_RST_ADDR;
            c_q.wrValid <= 2'h0;
            c_q.wrRise <= `DDRS_RST_DQ;
            c_q.wrFall <= `DDRS_RST_DQ;
            c_q.wrRiseEn <= 4'h0;
            c_q.wrFallEn <= 4'h0;
            c_q.rdStageV <= 1'b0;
            c_q.rdStageD <= `DDRS_RST_DQ;
            c_q.rdFlag <= 1'b0;
            c_q.dqOut <= `DDRS_RST_DQ;
            c_q.dqOe <= 1'b0;
            c_q.echo <= `DDRS_RST_ECHO;
        end else begin
            c_q <= c_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // Echo pair n runs with lane n; narrow build parks pairs 2 and 3
    always_comb begin
        for (int n = 0; n < `DDRS_LANES; n++) begin
            if (n < 2 || WIDE_BUILD) begin
                readEchoClock[n] = c_q.echo;
                readEchoClockN[n] = ~c_q.echo;
            end else begin
                readEchoClock[n] = 1'b0;
                readEchoClockN[n] = 1'b0;
            end
        end
    end

    // Valid 0 spans lanes 0 and 1, valid 1 lanes 2 and 3
    assign readValidFlag[0] = c_q.rdFlag;
    assign readValidFlag[1] = c_q.rdFlag & WIDE_BUILD;

    // Pin drive and user side
    assign dqOut = c_q.dqOut;
    assign dqOe = c_q.dqOe;
    assign cmdValid = c_q.cmdValid;
    assign cmdKind = c_q.cmdKind;
    assign cmdBank = c_q.cmdBank;
    assign cmdAddr = c_q.cmdAddr;
    assign wrValid = c_q.wrValid;
    assign wrRiseData = c_q.wrRise;
    assign wrFallData = c_q.wrFall;
    assign wrRiseLaneEn = c_q.wrRiseEn;
    assign wrFallLaneEn = c_q.wrFallEn;

endmodule : ddrs_pin_if

// ==== ddrs_pin_if_props.sv ====
// Port assertions for the DRAM pin interface
// Assumes it is bound to ddrs_pin_if and sees only its ports
`timescale 1ns/1ns
`include "ddrs_defs.svh"

module ddrs_pin_if_props
    import ddrs_pkg::*;
#(
    parameter bit WIDE_BUILD = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rdBeatValid,
    input wire logic [`DDRS_DQ_W-1:0] rdBeatData,
    input wire logic [`DDRS_DQ_W-1:0] dqOut,
    input wire logic dqOe,
    input wire logic [`DDRS_LANES-1:0] readEchoClock,
    input wire logic [`DDRS_LANES-1:0] readEchoClockN,
    input wire logic [1:0] readValidFlag,
    input wire logic cmdValid,
    input wire logic [`DDRS_BANK_W-1:0] cmdBank,
    input wire logic [`DDRS_ADDR_W-1:0] cmdAddr,
    input wire logic [`DDRS_PAIRS-1:0] wrValid,
    input wire logic [`DDRS_DQ_W-1:0] wrRiseData,
    input wire logic [`DDRS_LANES-1:0] wrRiseLaneEn
);
    // ====
    // All checks on the core clock
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_cmd_pulse: assert property (cmdValid |=> !cmdValid)
        else $error("command strobe longer than one cycle");
    a_cmd_hold: assert property (
        !cmdValid |-> $stable({cmdBank, cmdAddr}))
        else $error("command fields moved without strobe");
    a_wr_hold: assert property (!wrValid[0] |->
        $stable({wrRiseData[26:18], wrRiseData[8:0],
        wrRiseLaneEn[2], wrRiseLaneEn[0]}))
        else $error("pair 0 lanes moved without strobe");
    // First edge after reset release has no running history yet
    a_echo_run: assert property (
        $past(nrst) |-> readEchoClock[0] != $past(readEchoClock[0]))
        else $error("echo clock stalled");
    // Narrow build parks both legs of pairs 2 and 3
    a_echo_pair: assert property (
        readEchoClockN[1:0] == ~readEchoClock[1:0] && (!WIDE_BUILD ||
        readEchoClockN[3:2] == ~readEchoClock[3:2]))
        else $error("echo legs not complementary");
    a_flag_lead: assert property (rdBeatValid |=> readValidFlag[0]
        ##1 (dqOe && dqOut == $past(rdBeatData, 2)))
        else $error("read beat not flagged then driven");
    a_flag_lanes: assert property (
        readValidFlag[1] == (WIDE_BUILD && readValidFlag[0]))
        else $error("valid flags disagree");
    a_oe_cause: assert property (dqOe |-> $past(rdBeatValid, 2))
        else $error("data driven without a beat");
endmodule : ddrs_pin_if_props

bind ddrs_pin_if ddrs_pin_if_props #(.WIDE_BUILD(WIDE_BUILD)) i_props (
    .clk, .nrst, .rdBeatValid, .rdBeatData, .dqOut, .dqOe, .readEchoClock,
    .readEchoClockN, .readValidFlag, .cmdValid, .cmdBank, .cmdAddr,
    .wrValid, .wrRiseData, .wrRiseLaneEn
);

// ==== ddrs_pin_if_test.sv ====
// Self-checking bench for the DRAM pin interface
// Assumes the controller model makes the link and write clocks
`timescale 1ns/1ns

module ddrs_pin_if_test
    import ddrs_pkg::*;
;
    logic clk, nrst, mirrorSelect, rdBeatValid, dqOe, cmdValid;
    logic [35:0] rdBeatData, dqIn, ctrlDq, dqOut, wrRiseData, wrFallData;
    logic commandClock, cmdSelN, cmdWriteN, cmdRefreshN, spareSelectBall;
    logic [19:0] addrIn, cmdAddr;
    logic [3:0] bankIn, cmdBank, readEchoClock, readEchoClockN;
    logic [3:0] wrRiseLaneEn, wrFallLaneEn;
    logic [1:0] writeDataClock, writeDataClockN, writeByteMask;
    logic [1:0] readValidFlag, wrValid;
    ddrs_cmd_e cmdKind;
    int n_errors = 0;
    int cmp_count = 0;

    // ====
    // Data wires: the device wins while its enable is high
    assign dqIn = dqOe ? dqOut : ctrlDq;
    ddrs_pin_if i_dut (
        .clk, .nrst, .commandClock, .cmdSelN, .cmdWriteN, .cmdRefreshN,
        .addrIn, .bankIn, .mirrorSelect, .spareSelectBall, .writeDataClock,
        .writeDataClockN, .writeByteMask, .dqIn, .dqOut, .dqOe,
        .readEchoClock, .readEchoClockN, .readValidFlag, .cmdValid,
        .cmdKind, .cmdBank, .cmdAddr, .wrValid, .wrRiseData, .wrFallData,
        .wrRiseLaneEn, .wrFallLaneEn, .rdBeatValid, .rdBeatData
    );
    ddrs_ctrl_model i_ctrl (
        .commandClock, .cmdSelN, .cmdWriteN, .cmdRefreshN, .addrIn,
        .bankIn, .spareSelectBall, .writeDataClock, .writeDataClockN,
        .writeByteMask, .dqIn(ctrlDq)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ====
    // Helpers
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick
    task automatic wait_cmd();
        int i = 0;
        tick();
        while (cmdValid !== 1'b1 && i < 14) begin
            tick();
            i++;
        end
        check(cmdValid, 1'b1);
    endtask : wait_cmd
    function automatic logic [19:0] addr_of(input int k);
        return (k == 3) ? 20'hFFFFF : 20'h5A5A0 + 20'(k);
    endfunction : addr_of
    function automatic logic [3:0] bank_of(input int k);
        return (k == 3) ? 4'hF : 4'(k * 5);
    endfunction : bank_of
    function automatic logic [35:0] lanes(input logic [1:0] e);
        return {{9{e[1]}}, {9{e[0]}}, {9{e[1]}}, {9{e[0]}}};
    endfunction : lanes

    // ====
    // Scenarios
    task automatic t_cmds();
        fork
            begin
                for (int k = 0; k < 4; k++) begin
                    i_ctrl.drive_cmd(1'b0, 2'(3 - k), addr_of(k), bank_of(k));
                end
                i_ctrl.idle_cmd();
                i_ctrl.drive_cmd(1'b1, 2'h0, 20'h12345, 4'h3);
                i_ctrl.idle_cmd();
            end
            for (int k = 0; k < 4; k++) begin
                wait_cmd();
                check(cmdKind, 36'(k + 1));
                check(cmdBank, bank_of(k));
                check(cmdAddr, addr_of(k));
            end
        join
        repeat (14) begin
            tick();
            check(cmdValid, 1'b0);
        end
        $display("done: command decode");
    endtask : t_cmds
    task automatic t_write();
        logic [35:0] a;
        logic [1:0] m;
        logic [1:0] seen;
        for (int i = 0; i < 4; i++) begin
            a = 36'h123456789 + 36'(i);
            m = 2'(i);
            seen = 2'h0;
            i_ctrl.write_pair(a, ~a, m, ~m);
            tick();
            repeat (3) begin
                tick();
                seen = seen | wrValid;
            end
            check(seen, 2'h3);
            check(wrRiseLaneEn, {~m, ~m});
            check(wrFallLaneEn, {m, m});
            check(wrRiseData & lanes(~m), a & lanes(~m));
            check(wrFallData & lanes(m), ~a & lanes(m));
        end
        $display("done: write beats and masks");
    endtask : t_write
    task automatic t_read();
        tick();
        if (readEchoClock[0] === 1'b0) begin
            tick();
        end
        // Echo is high now, so the first beat lands on an echo rise
        {rdBeatValid, rdBeatData} = {1'b1, 36'hA5A5A5A5A};
        tick();
        rdBeatData = 36'h5A5A5A5A5;
        check({readValidFlag, dqOe}, 3'h6);
        tick();
        {rdBeatValid, rdBeatData} = {1'b0, 36'hA5A5A5A5A};
        check(readValidFlag, 2'h3);
        check({dqOe, readEchoClock, dqOut}, {5'h1F, 36'hA5A5A5A5A});
        tick();
        check({readValidFlag, dqOut}, {2'h0, 36'h5A5A5A5A5});
        check(readEchoClock, 4'h0);
        tick();
        check(dqOe, 1'b0);
        $display("done: read burst");
    endtask : t_read
    task automatic t_reset();
        tick();
        #3;
        nrst = 1'b0;
        #1;
        check({dqOe, readValidFlag, readEchoClockN}, 7'h0F);
        repeat (8) tick();
        nrst = 1'b1;
        tick();
        check(readEchoClock, 4'hF);
        $display("done: reset in mid run");
    endtask : t_reset
    task automatic t_mirror();
        mirrorSelect = 1'b1;
        repeat (12) tick();
        fork
            begin
                i_ctrl.drive_cmd(1'b0, 2'h3, 20'h00000, 4'h1);
                i_ctrl.idle_cmd();
            end
            wait_cmd();
        join
        check(cmdAddr, 20'h00020);
        $display("done: mirrored layout");
    endtask : t_mirror

    // ====
    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        n_errors++;
        complete_run();
    end
    initial begin
        {nrst, mirrorSelect, rdBeatValid} = 3'h0;
        rdBeatData = 36'h000000000;
        repeat (4) tick();
        check({dqOe, readEchoClockN, cmdKind}, {8'h0F, DDRS_NOP});
        repeat (4) tick();
        nrst = 1'b1;
        repeat (8) tick();
        t_cmds();
        t_write();
        t_read();
        t_reset();
        t_mirror();
        complete_run();
    end
endmodule : ddrs_pin_if_test

// ==== ddrs_pkg.sv ====
// Types shared by the pin interface modules
// Assumes ddrs_defs.svh is on the include path
`include "ddrs_defs.svh"

package ddrs_pkg;

    // ==========================================================
    // Command kinds
    typedef enum logic [2:0] {
        DDRS_NOP,
        DDRS_READ,
        DDRS_WRITE,
        DDRS_REFRESH,
        DDRS_CFG
    } ddrs_cmd_e;

    // ==========================================================
    // State of the command clock domain
    typedef struct packed {
        logic mirSync1;
        logic mirSync2;
        logic [`DDRS_ADDR_W-1:0] addr;
        logic [`DDRS_BANK_W-1:0] bank;
        ddrs_cmd_e kind;
        logic tog;
    } ddrs_link_s;

    // ==========================================================
    // State of the core clock domain
    typedef struct packed {
        logic [2:0] cmdSync;
        logic [`DDRS_PAIRS-1:0][2:0] wrSync;
        logic cmdValid;
        ddrs_cmd_e cmdKind;
        logic [`DDRS_BANK_W-1:0] cmdBank;
        logic [`DDRS_ADDR_W-1:0] cmdAddr;
        logic [`DDRS_PAIRS-1:0] wrValid;
        logic [`DDRS_DQ_W-1:0] wrRise;
        logic [`DDRS_DQ_W-1:0] wrFall;
        logic [`DDRS_LANES-1:0] wrRiseEn;
        logic [`DDRS_LANES-1:0] wrFallEn;
        logic rdStageV;
        logic [`DDRS_DQ_W-1:0] rdStageD;
        logic rdFlag;
        logic [`DDRS_DQ_W-1:0] dqOut;
        logic dqOe;
        logic echo;
    } ddrs_core_s;

    // ==========================================================
    // State of one write beat capture cell
    typedef struct packed {
        logic [`DDRS_PAIR_W-1:0] beat;
        logic mask;
        logic [`DDRS_PAIR_W-1:0] early;
        logic earlyMask;
        logic tog;
    } ddrs_cap_s;

endpackage : ddrs_pkg
